/* File: scsp_checker.sv */
`timescale 1ns/100ps
`default_nettype none
// Watches the pins between host and device; serial rules gated on mode
module scsp_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic mode,
    input wire logic sck,
    input wire logic mosi,
    input wire logic ssn,
    input wire logic miso_h_oe,
    input wire logic miso_d_oe,
    input wire logic flt_d_o,
    input wire logic flt_d_oe
);
    logic [5:0] rise_cnt;
    logic       mode_q;
    logic       ser_q;

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // Counts clock rises inside one frame; cleared whenever deselected
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rise_cnt <= 6'h00;
        end else if (ssn) begin
            rise_cnt <= 6'h00;
        end else if ($rose(sck)) begin
            rise_cnt <= rise_cnt + 6'h01;
        end
    end
    // Serial mode held for two cycles; pins change meaning on a mode switch
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode_q <= 1'b0;
        end else begin
            mode_q <= mode;
        end
    end
    assign ser_q = !mode && !mode_q;

    a_sck_idle_desel: assert property ((ser_q && ssn) |-> !sck)
        else $error("serial clock moved while deselected");
    a_frame_len_16: assert property
        ((ser_q && $rose(ssn)) |-> rise_cnt == 16)
        else $error("frame did not carry sixteen clocks");
    a_lead_clock_low: assert property ((ser_q && $fell(ssn)) |-> !sck [*8])
        else $error("clock rose before the lead half ended");
    a_mosi_hold_high: assert property
        ((ser_q && !ssn && sck && $past(sck)) |-> $stable(mosi))
        else $error("data line changed while clock high");
    a_out_drive_on: assert property
        ((ser_q && $fell(ssn)) |-> ##[1:6] miso_d_oe)
        else $error("device did not drive its output in a frame");
    a_out_drive_off: assert property
        ((ser_q && $rose(ssn)) |-> ##[1:6] !miso_d_oe)
        else $error("device kept driving after the frame");
    a_par_no_drive: assert property
        ((mode && $past(mode, 6)) |-> !miso_d_oe)
        else $error("device drove the shared line in parallel mode");
    a_host_drive_par: assert property
        (miso_h_oe |-> (mode && !miso_d_oe))
        else $error("host drove the shared line outside parallel mode");
    a_fault_pin_low: assert property (flt_d_oe |-> !flt_d_o)
        else $error("fault line driven high");

    c_frame_done: cover property (ser_q && $rose(ssn) && rise_cnt == 16);
    c_fault_seen: cover property ($rose(flt_d_oe));
    c_par_drive:  cover property ($rose(miso_h_oe));
endmodule // scsp_checker
`default_nettype wire

/* File: scsp_device.sv */
`timescale 1ns/100ps
`default_nettype none
// Functional notes
// [R1] Mode low serial; high, strap low parallel
// [R2] Host keeps serial clock at most 33 MHz
// [R3] Select falling presents outgoing MSB
// [R4] Clock idle when deselected; sample rising
// [R5] Next outgoing bit on each falling edge
// [R6] Outgoing word is previously stored word
// [R7] Select rising loads word if enabled
// [R8] Word: enable, seven control, eight state
// [R9] Two readable writable eight-bit registers
// [R10] Both registers clear at reset
// [R11] State bits 3..0 drive outputs D..A
// [R12] Serial mode ignores pump, shutdown pins
// [R13] Control bit 7 is write enable
// [R14] Fault bit sticky until written zero
// [R15] Control bit 5 selects sleep
// [R16] Control bit 4 disables fault shutdown
// [R17] Control bit 3 disables undervoltage check
// [R18] Control bits 2, 0 do nothing
// [R19] Bit 1 pump enable; toggle restarts
// [R20] Daisy chain joins output to next input
// [R21] Parallel inputs 4..1 drive outputs D..A
// [R22] Host uses the defined routing codes
// [R23] Fault shutdown: outputs low, pump off
module scsp_device (
    input  wire logic pclk,
    input  wire logic presetn,
    scsp_if.device    bus,
    input  wire logic vdd_fault,
    input  wire logic vpp_fault,
    output logic      hv_out_a,
    output logic      hv_out_b,
    output logic      hv_out_c,
    output logic      hv_out_d,
    output logic      pump_on,
    output logic      sleep_on,
    output logic      hv_undervoltage_check_off,
    output logic      fault_status
);
    localparam int W = scsp_pkg::WORD_BITS;
    localparam int R = scsp_pkg::REG_BITS;
    localparam int N = scsp_pkg::PIN_COUNT;
    // Idle pin levels: select high, so release from reset shows no edge
    localparam logic [N-1:0] PIN_IDLE = N'(1) << scsp_pkg::PIN_SSN;

    logic [N-1:0]     pin_raw;
    logic [N-1:0]     pin_s1;
    logic [N-1:0]     pin_s2;
    logic [N-1:0]     pin_s3;
    logic [W-1:0]     rx_sr;
    logic [W-1:0]     tx_sr;
    logic [R-1:0]     switch_output_state;
    logic [R-1:0]     device_control_status;
    logic             shutdown;
    logic [3:0]       hv_q;
    logic             miso_oe_q;

    // Every pin arrives from the host's domain
    assign pin_raw[scsp_pkg::PIN_SCK]   = bus.sck;
    assign pin_raw[scsp_pkg::PIN_MOSI]  = bus.mosi;
    assign pin_raw[scsp_pkg::PIN_MISO]  = bus.miso;
    assign pin_raw[scsp_pkg::PIN_SSN]   = bus.ssn;
    assign pin_raw[scsp_pkg::PIN_MODE]  = bus.mode;
    assign pin_raw[scsp_pkg::PIN_FLIP]  = bus.flip;
    assign pin_raw[scsp_pkg::PIN_PUMP]  = bus.pump_pin;
    assign pin_raw[scsp_pkg::PIN_FSHUT] = bus.fshut_pin;

    // Two-stage synchroniser plus one stage for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1 <= PIN_IDLE;
            pin_s2 <= PIN_IDLE;
            pin_s3 <= PIN_IDLE;
        end else begin
            pin_s1 <= pin_raw;
            pin_s2 <= pin_s1;
            pin_s3 <= pin_s2;
        end
    end

    // Decoded pin levels and edges, all from the second stage onward
    wire sck_s     = pin_s2[scsp_pkg::PIN_SCK];
    wire sck_d     = pin_s3[scsp_pkg::PIN_SCK];
    wire ssn_s     = pin_s2[scsp_pkg::PIN_SSN];
    wire ssn_d     = pin_s3[scsp_pkg::PIN_SSN];
    wire mosi_s    = pin_s2[scsp_pkg::PIN_MOSI];
    wire pump_pin  = pin_s2[scsp_pkg::PIN_PUMP];
    wire fshut_pin = pin_s2[scsp_pkg::PIN_FSHUT];
    wire serial    = ~pin_s2[scsp_pkg::PIN_MODE]; // [R1]
    wire parallel  = pin_s2[scsp_pkg::PIN_MODE]
                   & ~pin_s2[scsp_pkg::PIN_FLIP]; // [R1]
    wire sck_rise  = sck_s & ~sck_d;
    wire sck_fall  = ~sck_s & sck_d;
    wire ssn_fall  = ~ssn_s & ssn_d;
    wire ssn_rise  = ssn_s & ~ssn_d;
    wire in_frame  = serial & ~ssn_s;
    // Clock edges while deselected are ignored
    wire shift_in  = in_frame & sck_rise; // [R4]
    wire shift_out = in_frame & ~ssn_fall & sck_fall; // [R5]
    wire load_out  = serial & ssn_fall; // [R3]
    wire commit    = serial & ssn_rise & rx_sr[scsp_pkg::WE_BIT]; // [R7] [R13]

    // Readback carries the live sticky fault in place of the stored bit
    wire [R-1:0] ctrl_rd = (device_control_status & ~scsp_pkg::FAULT_MASK)
                         | (fault_status ? scsp_pkg::FAULT_MASK : '0);

    // Control bits, or pins in parallel mode except sleep, which is off there; bits 2 and 0 feed nothing
    wire ctl_sleep = device_control_status[scsp_pkg::SLEEP_BIT]; // [R15]
    wire ctl_fshut = device_control_status[scsp_pkg::FSHUT_BIT]; // [R16]
    wire ctl_uvoff = device_control_status[scsp_pkg::UVOFF_BIT]; // [R17]
    wire ctl_pump  = device_control_status[scsp_pkg::PUMP_BIT]; // [R19]
    wire pump_req  = serial ? ctl_pump : pump_pin; // [R12] [R19]
    wire shut_en   = serial ? ~ctl_fshut : ~fshut_pin; // [R12] [R16]
    wire uv_off    = serial ? ctl_uvoff : ~pump_pin; // [R17]
    wire sleep_req = serial & ctl_sleep; // [R15]

    // Either supply fault; the high-voltage check can be switched off
    wire fault_det = vdd_fault | (vpp_fault & ~uv_off); // [R17]

    // Sticky fault: a write of zero clears, a live fault always wins
    wire next_fault = fault_det
                    | (commit ? (rx_sr[scsp_pkg::WE_BIT-1] & fault_status)
                              : fault_status); // [R14]

    // Shutdown latch holds until the pump request goes low
    wire next_shutdown = (fault_det & shut_en)
                       | (shutdown & pump_req); // [R23] [R19]

    // Output selection: shutdown forces all switches open
    wire [3:0] par_code = {pin_s2[scsp_pkg::PIN_SSN],
                           pin_s2[scsp_pkg::PIN_MISO],
                           pin_s2[scsp_pkg::PIN_MOSI],
                           pin_s2[scsp_pkg::PIN_SCK]}; // [R21]
    wire [3:0] next_hv = shutdown ? '0 :
                         serial   ? switch_output_state[scsp_pkg::HV_BITS-1:0] :
                         parallel ? par_code : '0; // [R11] [R21] [R23]

    // Incoming word: last sixteen bits seen on rising edges
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_sr <= '0;
        end else if (shift_in) begin
            rx_sr <= {rx_sr[W-2:0], mosi_s}; // [R4] [R8]
        end
    end

    // Outgoing word; bits shifted in arrive sixteen clocks later for chains
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_sr <= '0;
        end else if (load_out) begin
            tx_sr <= {ctrl_rd, switch_output_state}; // [R3] [R6] [R9]
        end else if (shift_out) begin
            tx_sr <= {tx_sr[W-2:0], rx_sr[0]}; // [R5] [R6] [R20]
        end
    end

    // The two registers, updated only by an enabled transfer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            switch_output_state   <= scsp_pkg::REG_RESET; // [R10]
            device_control_status <= scsp_pkg::REG_RESET; // [R10]
        end else if (commit) begin
            switch_output_state   <= rx_sr[R-1:0]; // [R8] [R9]
            device_control_status <= rx_sr[W-1:R]; // [R8] [R9] [R18]
        end
    end

    // Fault and shutdown state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fault_status <= 1'b0;
            shutdown     <= 1'b0;
        end else begin
            fault_status <= next_fault; // [R14]
            shutdown     <= next_shutdown; // [R23]
        end
    end

    // Registered outputs; sleep also stops the pump
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            hv_q                      <= '0;
            pump_on                   <= 1'b0;
            sleep_on                  <= 1'b0;
            hv_undervoltage_check_off <= 1'b0;
            miso_oe_q                 <= 1'b0;
        end else begin
            hv_q                      <= next_hv;
            pump_on                   <= pump_req & ~shutdown & ~sleep_req;
            sleep_on                  <= sleep_req; // [R15]
            hv_undervoltage_check_off <= uv_off; // [R17]
            miso_oe_q                 <= in_frame; // [R3]
        end
    end

    // Fault line pulls low while a detected fault is present; no vpp_fault while the check is off
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.flt_d_oe <= 1'b0;
            bus.flt_d_o  <= 1'b0;
        end else begin
            bus.flt_d_oe <= fault_det;
            bus.flt_d_o  <= 1'b0;
        end
    end

    // Data line is released outside frames so parallel input can use it
    assign bus.miso_d_o  = tx_sr[W-1]; // [R3] [R5]
    assign bus.miso_d_oe = miso_oe_q;
    assign hv_out_a = hv_q[0];
    assign hv_out_b = hv_q[1];
    assign hv_out_c = hv_q[2];
    assign hv_out_d = hv_q[3];
endmodule // scsp_device
`default_nettype wire

/* File: scsp_host.sv */
`timescale 1ns/100ps
`default_nettype none
// Host end: APB registers, serial frame engine, parallel pin driver
module scsp_host (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    scsp_if.host             bus
);
    localparam int W = scsp_pkg::WORD_BITS;
    localparam int C = scsp_pkg::C_BITS;

    scsp_pkg::scsp_host_st_e st;
    logic [C-1:0]   ctrl;
    logic [W-1:0]   tx_sh;
    logic [W-1:0]   rx_word;
    logic [7:0]     half;
    logic [7:0]     tmr;
    logic [3:0]     bitn;
    logic [1:0]     miso_sy;
    logic [1:0]     flt_sy;

    // Bus decode
    wire setup   = psel & ~penable;
    wire access  = psel & penable & pready;
    wire hit     = (paddr == scsp_pkg::ADDR_CTRL)
                 | (paddr == scsp_pkg::ADDR_TX)
                 | (paddr == scsp_pkg::ADDR_RX)
                 | (paddr == scsp_pkg::ADDR_STAT)
                 | (paddr == scsp_pkg::ADDR_HALF);
    wire wr      = access & pwrite & ~pslverr;
    wire par     = ctrl[scsp_pkg::C_MODE];
    wire busy    = (st != scsp_pkg::H_IDLE);
    wire start   = wr & (paddr == scsp_pkg::ADDR_TX) & ~busy & ~par;
    wire tmr_end = (tmr == half - 8'h01);
    wire [3:0] code = ctrl[C-1:scsp_pkg::C_CODE_LO];
    // Half period never shorter than the fastest legal clock allows
    wire [7:0] half_wr = (pwdata[7:0] < scsp_pkg::HALF_MIN)
                       ? scsp_pkg::HALF_MIN : pwdata[7:0]; // [R2]
    wire [31:0] rd_mux =
        (paddr == scsp_pkg::ADDR_CTRL) ? {24'h000000, ctrl} :
        (paddr == scsp_pkg::ADDR_RX)   ? {16'h0000, rx_word} :
        (paddr == scsp_pkg::ADDR_STAT) ? {30'h00000000, flt_sy[1], busy} :
        (paddr == scsp_pkg::ADDR_HALF) ? {24'h000000, half} : 32'h00000000;

    // Zero-wait slave: answer one cycle after setup
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
            prdata  <= 32'h00000000;
        end else begin
            pready  <= setup;
            pslverr <= setup & ~hit;
            prdata  <= setup ? rd_mux : 32'h00000000;
        end
    end

    // Software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= '0;
            half <= scsp_pkg::HALF_DEFAULT;
        end else if (wr && paddr == scsp_pkg::ADDR_CTRL) begin
            ctrl <= pwdata[C-1:0]; // [R22]
        end else if (wr && paddr == scsp_pkg::ADDR_HALF) begin
            half <= half_wr; // [R2]
        end
    end

    // Returned data line and fault line come from the device's domain
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso_sy <= 2'h0;
            flt_sy  <= 2'h3;
        end else begin
            miso_sy <= {miso_sy[0], bus.miso};
            flt_sy  <= {flt_sy[0], bus.fault_out_n};
        end
    end

    // Frame engine: data set up on falling clock, sampled on rising
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st      <= scsp_pkg::H_IDLE;
            tmr     <= 8'h00;
            bitn    <= 4'h0;
            tx_sh   <= '0;
            rx_word <= '0;
        end else begin
            tmr <= (st == scsp_pkg::H_IDLE || tmr_end) ? 8'h00 : tmr + 8'h01;
            unique case (st)
                scsp_pkg::H_IDLE: if (start) begin
                    tx_sh <= pwdata[W-1:0];
                    bitn  <= 4'h0;
                    st    <= scsp_pkg::H_LEAD;
                end
                scsp_pkg::H_LEAD, scsp_pkg::H_LO: if (tmr_end) begin
                    rx_word <= {rx_word[W-2:0], miso_sy[1]};
                    st      <= scsp_pkg::H_HI;
                end
                scsp_pkg::H_HI: if (tmr_end) begin
                    bitn  <= bitn + 4'h1;
                    tx_sh <= {tx_sh[W-2:0], 1'b0};
                    st    <= (bitn == 4'hF) ? scsp_pkg::H_TAIL
                                            : scsp_pkg::H_LO;
                end
                scsp_pkg::H_TAIL: if (tmr_end) st <= scsp_pkg::H_GAP;
                scsp_pkg::H_GAP:  if (tmr_end) st <= scsp_pkg::H_IDLE;
            endcase
        end
    end

    // Pin drive: parallel code straight to pins, else the frame engine
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            bus.mode      <= 1'b0;
            bus.flip      <= 1'b0;
            bus.pump_pin  <= 1'b0;
            bus.fshut_pin <= 1'b0;
            bus.sck       <= 1'b0;
            bus.mosi      <= 1'b0;
            bus.ssn       <= 1'b1;
            bus.miso_h_o  <= 1'b0;
            bus.miso_h_oe <= 1'b0;
        end else begin
            bus.mode      <= par;
            bus.flip      <= ctrl[scsp_pkg::C_FLIP];
            bus.pump_pin  <= ctrl[scsp_pkg::C_PUMP];
            bus.fshut_pin <= ctrl[scsp_pkg::C_FSHUT];
            bus.miso_h_oe <= par;
            bus.miso_h_o  <= par & code[2];
            if (par) begin
                bus.sck  <= code[0];
                bus.mosi <= code[1];
                bus.ssn  <= code[3];
            end else begin
                // Clock stays low whenever select is high
                bus.sck  <= (st == scsp_pkg::H_HI); // [R4]
                bus.mosi <= busy & tx_sh[W-1]; // [R4] [R8]
                bus.ssn  <= ~(busy && st != scsp_pkg::H_GAP);
            end
        end
    end
endmodule // scsp_host
`default_nettype wire

/* File: scsp_if.sv */
`timescale 1ns/100ps
`default_nettype none
// Pins between host and switch driver; resolves shared and open-drain wires
interface scsp_if;
    logic mode;
    logic flip;
    logic sck;
    logic mosi;
    logic ssn;
    logic miso_h_o;
    logic miso_h_oe;
    logic miso_d_o;
    logic miso_d_oe;
    logic miso;
    logic pump_pin;
    logic fshut_pin;
    logic flt_d_o;
    logic flt_d_oe;
    logic fault_out_n;
    // Undriven shared line falls to the pull-down level
    assign miso = miso_d_oe ? miso_d_o : (miso_h_oe ? miso_h_o : 1'b0);
    // Open drain with pull-up
    assign fault_out_n = flt_d_oe ? flt_d_o : 1'b1;
    modport device (input mode, flip, sck, mosi, ssn, miso, pump_pin,
                    fshut_pin, output miso_d_o, miso_d_oe, flt_d_o,
                    flt_d_oe);
    modport host (output mode, flip, sck, mosi, ssn, miso_h_o, miso_h_oe,
                  pump_pin, fshut_pin, input miso, fault_out_n);
endinterface
`default_nettype wire

/* File: scsp_pkg.sv */
package scsp_pkg;
    // Serial word layout
    localparam int WORD_BITS = 16;
    localparam int REG_BITS  = 8;
    localparam int HV_BITS   = 4;
    localparam int WE_BIT    = 15;
    localparam logic [7:0] REG_RESET  = 8'h00;
    localparam logic [7:0] FAULT_MASK = 8'h40;
    // Control register bit positions
    localparam int SLEEP_BIT = 5;
    localparam int FSHUT_BIT = 4;
    localparam int UVOFF_BIT = 3;
    localparam int PUMP_BIT  = 1;
    // Device pin sample vector positions
    localparam int PIN_SCK   = 0;
    localparam int PIN_MOSI  = 1;
    localparam int PIN_MISO  = 2;
    localparam int PIN_SSN   = 3;
    localparam int PIN_MODE  = 4;
    localparam int PIN_FLIP  = 5;
    localparam int PIN_PUMP  = 6;
    localparam int PIN_FSHUT = 7;
    localparam int PIN_COUNT = 8;
    // Host register map, byte addresses
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_TX   = 8'h04;
    localparam logic [7:0] ADDR_RX   = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_HALF = 8'h10;
    // Host control fields
    localparam int C_MODE    = 0;
    localparam int C_FLIP    = 1;
    localparam int C_PUMP    = 2;
    localparam int C_FSHUT   = 3;
    localparam int C_CODE_LO = 4;
    localparam int C_BITS    = 8;
    // Serial clock timing
    localparam int PCLK_MHZ    = 50;
    localparam int SCK_MAX_MHZ = 33;
    localparam int HALF_MIN_I  =
        (PCLK_MHZ + 2 * SCK_MAX_MHZ - 1) / (2 * SCK_MAX_MHZ);
    localparam logic [7:0] HALF_MIN     = 8'(HALF_MIN_I);
    localparam logic [7:0] HALF_DEFAULT = 8'h08;
    typedef enum logic [2:0] {
        H_IDLE, H_LEAD, H_HI, H_LO, H_TAIL, H_GAP
    } scsp_host_st_e;
endpackage

/* File: testbench.sv */
`timescale 1ns/100ps
`default_nettype none
// Drives the host over APB and watches the device's switch outputs
module testbench;
    logic        pclk, presetn, psel, penable, pwrite;
    logic        vdd_fault, vpp_fault, pready, pslverr;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata;
    logic        hv_a, hv_b, hv_c, hv_d, pump_on, sleep_on, uv_off;
    logic        fault_status;
    logic [3:0]  hv;
    int          fail_count, samples_checked;
    // Rows: serial word and expected {hv d..a, pump, sleep, check off}
    logic [15:0] row_w [5] = '{16'h8203, 16'h8A05, 16'hA209, 16'h8506,
                               16'h000C};
    logic [6:0]  row_o [5] = '{7'h1C, 7'h2D, 7'h4A, 7'h30, 7'h30};

    assign hv = {hv_d, hv_c, hv_b, hv_a};
    scsp_if scsp_if_i ();
    scsp_host scsp_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .bus(scsp_if_i));
    scsp_device scsp_device_i (.pclk(pclk), .presetn(presetn),
        .bus(scsp_if_i), .vdd_fault(vdd_fault), .vpp_fault(vpp_fault),
        .hv_out_a(hv_a), .hv_out_b(hv_b), .hv_out_c(hv_c), .hv_out_d(hv_d),
        .pump_on(pump_on), .sleep_on(sleep_on),
        .hv_undervoltage_check_off(uv_off), .fault_status(fault_status));
    scsp_checker scsp_checker_i (.pclk(pclk), .presetn(presetn),
        .mode(scsp_if_i.mode), .sck(scsp_if_i.sck), .mosi(scsp_if_i.mosi),
        .ssn(scsp_if_i.ssn), .miso_h_oe(scsp_if_i.miso_h_oe),
        .miso_d_oe(scsp_if_i.miso_d_oe), .flt_d_o(scsp_if_i.flt_d_o),
        .flt_d_oe(scsp_if_i.flt_d_oe));

    // Free-running 50 MHz clock
    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    task automatic chk(input string nm, input logic [31:0] seen, exp);
        samples_checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic final_report();
        if (fail_count == 0 && samples_checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1 && n < 50) begin
            @(posedge pclk);
            n++;
        end
        if (n >= 50) begin
            fail_count++;
            final_report();
        end
        r = prdata;
        e = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask

    // Sends a word, waits out busy and the latch, returns the word received
    task automatic frame(input logic [15:0] w, output logic [15:0] rx);
        logic [31:0] r;
        logic        e;
        int          n;
        apb(1'b1, scsp_pkg::ADDR_TX, {16'h0000, w}, r, e);
        n = 0;
        r = 32'h00000001;
        while (r[0] !== 1'b0 && n < 200) begin
            apb(1'b0, scsp_pkg::ADDR_STAT, 32'h00000000, r, e);
            n++;
        end
        if (n >= 200) begin
            fail_count++;
            final_report();
        end
        repeat (10) @(posedge pclk);
        apb(1'b0, scsp_pkg::ADDR_RX, 32'h00000000, r, e);
        rx = r[15:0];
    endtask

    // Hang guard, well beyond the expected run length
    initial begin
        #1000000;
        fail_count++;
        final_report();
    end

    initial begin
        logic [31:0] r;
        logic        e;
        logic [15:0] rx, stored;
        int          i;
        presetn   = 1'b0;
        psel      = 1'b0;
        penable   = 1'b0;
        pwrite    = 1'b0;
        paddr     = 8'h00;
        pwdata    = 32'h00000000;
        vdd_fault = 1'b0;
        vpp_fault = 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        chk("hv after reset", hv, 32'h0);
        chk("fault after reset", fault_status, 32'h0);
        apb(1'b0, scsp_pkg::ADDR_HALF, 32'h0, r, e);
        chk("half default", r, 32'(scsp_pkg::HALF_DEFAULT));
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk("unmapped error", e, 32'h1);
        chk("unmapped data", r, 32'h0);
        // Too short a half period is clamped to the fastest legal clock
        apb(1'b1, scsp_pkg::ADDR_HALF, 32'h0, r, e);
        apb(1'b0, scsp_pkg::ADDR_HALF, 32'h0, r, e);
        chk("half clamp", r, 32'(scsp_pkg::HALF_MIN));
        apb(1'b1, scsp_pkg::ADDR_HALF, 32'(scsp_pkg::HALF_DEFAULT), r, e);
        // Ordinary serial frames; each returns the previously stored word
        stored = 16'h0000;
        for (i = 0; i < 5; i++) begin
            frame(row_w[i], rx);
            chk("readback", rx & 16'h7FFF, stored);
            if (row_w[i][scsp_pkg::WE_BIT]) stored = row_w[i] & 16'h7FFF;
            chk("outputs", {hv, pump_on, sleep_on, uv_off}, row_o[i]);
        end
        // Every parallel code, pump pin high, then the wrong strap
        for (i = 0; i < 16; i++) begin
            apb(1'b1, scsp_pkg::ADDR_CTRL, {24'h0, i[3:0], 4'h5}, r, e);
            repeat (8) @(posedge pclk);
            chk("parallel code", hv, i[3:0]);
        end
        apb(1'b1, scsp_pkg::ADDR_CTRL, 32'h000000F7, r, e);
        repeat (8) @(posedge pclk);
        chk("strap high", hv, 32'h0);
        // Serial again with both pins high; register bits must rule
        apb(1'b1, scsp_pkg::ADDR_CTRL, 32'h0000000C, r, e);
        frame(16'h800F, rx);
        chk("pump pin ignored", pump_on, 32'h0);
        frame(16'h820F, rx);
        vdd_fault <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("shutdown outs", hv, 32'h0);
        chk("shutdown pump", pump_on, 32'h0);
        chk("fault set", fault_status, 32'h1);
        chk("fault line", scsp_if_i.fault_out_n, 32'h0);
        vdd_fault <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("fault sticky", fault_status, 32'h1);
        chk("fault line free", scsp_if_i.fault_out_n, 32'h1);
        chk("outs held off", hv, 32'h0);
        frame(16'h800F, rx);
        chk("fault cleared", fault_status, 32'h0);
        chk("restart outs", hv, 32'hF);
        frame(16'h820F, rx);
        chk("pump restart", pump_on, 32'h1);
        // Shutdown disabled: fault reported, nothing else changes
        frame(16'h920F, rx);
        vpp_fault <= 1'b1;
        repeat (8) @(posedge pclk);
        chk("no shutdown outs", hv, 32'hF);
        chk("no shutdown pump", pump_on, 32'h1);
        chk("fault reported", fault_status, 32'h1);
        vpp_fault <= 1'b0;
        repeat (4) @(posedge pclk);
        // Reset in mid-run: registers clear, no false frame on release
        presetn <= 1'b0;
        repeat (10) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        chk("hv after mid reset", hv, 32'h0);
        chk("fault after mid reset", fault_status, 32'h0);
        chk("no false frame", scsp_if_i.miso_d_oe, 32'h0);
        frame(16'h0000, rx);
        chk("regs after mid reset", rx, 16'h0000);
        final_report();
    end
endmodule // testbench
`default_nettype wire
